// [verilog/aasa_pkg.sv]
// package: constants and types for the async serial adapter
`default_nettype none
package aasa_pkg;
  localparam logic [7:0] SELECT_CODE = 8'h2b;
  // status byte bit positions
  localparam int ST_RXAV = 7;
  localparam int ST_TXNEED = 6;
  localparam int ST_ERR = 5;
  localparam int ST_CTS = 4;
  localparam int ST_SRD = 3;
  localparam int ST_CD = 2;
  localparam int ST_DSR = 1;
  localparam int ST_RING = 0;
  // modem control bits
  localparam int MC_BREAK = 3;
  localparam int MC_STD = 2;
  localparam int MC_DTR = 1;
  localparam int MC_RTS = 0;
  // parameter command bits
  localparam int PA_TWOSTOP = 7;
  localparam int PA_LONG = 6;
  localparam int PA_NOPAR = 5;
  localparam int PA_EVEN = 4;
  // auxiliary command bits
  localparam int AX_LOW = 7;
  localparam int AX_RING = 6;
  localparam int AX_TXIE = 5;
  localparam int AX_FIELD = 4;
  localparam logic [7:0] PARAMS_RESET = 8'h00;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_HZ = 10_000_000;
  localparam int OVERSAMPLE = 16;
  // half-bit-rate units (x2) so 134.5 stays exact
  localparam int RATE2 [16] = '{100, 150, 220, 269, 300, 600, 1200, 2400,
                                3600, 4000, 4800, 7200, 9600, 14400,
                                19200, 38400};
  // tick divider per code: clk/(16*rate), rounded down, at least one
  function automatic logic [15:0] rate_div(input logic [3:0] code);
    int d;
    d = (2 * CLK_HZ) / (OVERSAMPLE * RATE2[code]);
    if (d < 1) d = 1;
    return d[15:0];
  endfunction : rate_div
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_CLEAR = 3'b001, CMD_INPUT = 3'b010,
    CMD_OUTPUT = 3'b011, CMD_MODEM = 3'b100, CMD_PARAMS = 3'b101,
    CMD_INMODE = 3'b110, CMD_AUX = 3'b111
  } aasa_cmd_type;
  typedef struct packed {
    logic cts;
    logic srd;
    logic cd;
    logic dsr;
    logic ring;
  } aasa_modem_in_type;
  typedef struct packed {
    logic txd;
    logic std;
    logic dtr;
    logic rts;
  } aasa_modem_out_type;
endpackage : aasa_pkg
`default_nettype wire

// [verilog/aasa_fifo.sv]
// synchronous valid/ready fifo for the transmit path
`default_nettype none
module aasa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  // storage has no reset: contents matter only below the count
  always_ff @(posedge clk_i) begin
    if (ce_i && push) mem[wr_reg] <= in_data_i;
  end
  // pointers wrap at depth; flush empties without touching storage
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && flush_i)) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : aasa_fifo
`default_nettype wire

// [verilog/aasa_adapter.sv]
// command-driven asynchronous serial adapter, full duplex
//
// Overview of operation
// - commands act only while selected by 2B
// - full duplex start-stop, 50 to 19200 baud
// - clear aborts, resets flags modes, sets need
// - status byte layout of flags and modem
// - error bit holds until next character
// - status mode input returns status byte
// - output loads byte, clears need until sent
// - data mode input returns char, clears flag
// - modem byte drives break, std, dtr, rts
// - parameter bits: stops, length, parity
// - low nibble picks one of sixteen rates
// - parameter sets both rates equal
// - input mode bit0 picks data or status
// - auxiliary bit7 selects low data bits
// - auxiliary bit6 ring mode gates interrupts
// - auxiliary bit5 enables transmit interrupt
// - auxiliary low nibble sets receive rate
// - leaving ring mode drops ring interrupt
// - one interrupt at level four for events
`default_nettype none
module aasa_adapter (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic SEL_STB_I,
  input wire logic [7:0] SEL_CODE_I,
  input wire aasa_pkg::aasa_cmd_type CMD_I,
  input wire logic [7:0] CMD_DATA_I,
  output logic [7:0] RD_DATA_O,
  output logic CMD_READY_O,
  output logic SELECTED_O,
  output logic IRQ_O,
  input wire logic RXD_I,
  input wire aasa_pkg::aasa_modem_in_type MODEM_I,
  output aasa_pkg::aasa_modem_out_type MODEM_O
);
  import aasa_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_STOP = 2'b10
  } aasa_tx_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_SHIFT = 2'b10, RX_STOP = 2'b11
  } aasa_rx_type;

  // configuration and flags
  logic sel_reg;
  logic [7:0] params_reg;
  logic [3:0] rx_rate_reg;
  logic [3:0] modem_reg;
  logic in_data_mode_reg, low_mode_reg, ring_mode_reg, txie_reg;
  logic rx_avail_reg, err_reg, tx_need_reg, ring_irq_reg;
  logic [7:0] rx_buf_reg, rd_reg;

  // command decode, gated by selection
  wire cmd_ok = sel_reg && (CMD_I != CMD_NONE);
  wire do_clear = cmd_ok && (CMD_I == CMD_CLEAR);
  wire do_input = cmd_ok && (CMD_I == CMD_INPUT);
  wire do_output = cmd_ok && (CMD_I == CMD_OUTPUT);
  wire do_modem = cmd_ok && (CMD_I == CMD_MODEM);
  wire do_params = cmd_ok && (CMD_I == CMD_PARAMS);
  wire do_inmode = cmd_ok && (CMD_I == CMD_INMODE);
  wire do_aux = cmd_ok && (CMD_I == CMD_AUX);
  // a low-mode aux carries no rate; rate aux keeps bit 7 high
  wire aux_low = CMD_DATA_I[AX_LOW];
  wire aux_rate_ok = do_aux && !(aux_low && !low_mode_reg);

  // frame shape from parameters
  wire two_stop = params_reg[PA_TWOSTOP];
  wire par_on = !params_reg[PA_NOPAR];
  wire par_even = params_reg[PA_EVEN];
  // data bits: 8/7 normal, 6/5 low mode
  wire [3:0] nbits = low_mode_reg ? (params_reg[PA_LONG] ? 4'h6 : 4'h5)
                                  : (params_reg[PA_LONG] ? 4'h8 : 4'h7);

  // status byte assembly
  wire [7:0] status = {rx_avail_reg, tx_need_reg, err_reg, MODEM_I.cts,
                       MODEM_I.srd, MODEM_I.cd, MODEM_I.dsr,
                       MODEM_I.ring};

  // transmit fifo; need flag tracks fifo drain and shifter
  logic f_valid, f_ready, f_in_ready;
  logic [7:0] f_data;
  aasa_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .flush_i(do_clear),
    .in_valid_i(do_output),
    .in_ready_o(f_in_ready),
    .in_data_i(CMD_DATA_I),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  // output only taken with room; host waits for need anyway
  assign CMD_READY_O = f_in_ready;

  // baud tick generators, 16x oversample
  logic [15:0] tx_div_reg, rx_div_reg;
  logic [3:0] tx_sub_reg;
  wire [15:0] tx_lim = rate_div(params_reg[3:0]);
  wire [15:0] rx_lim = rate_div(rx_rate_reg);
  wire tx_tick = (tx_div_reg >= tx_lim - 16'h0001);
  wire rx_tick = (rx_div_reg >= rx_lim - 16'h0001);
  wire tx_bit = tx_tick && (tx_sub_reg == 4'hf);

  // dividers run free; the receiver realigns on each start edge
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      tx_div_reg <= '0;
      rx_div_reg <= '0;
      tx_sub_reg <= '0;
    end else if (CE_I) begin
      tx_div_reg <= tx_tick ? 16'h0000 : tx_div_reg + 16'h0001;
      rx_div_reg <= rx_tick ? 16'h0000 : rx_div_reg + 16'h0001;
      if (tx_tick) tx_sub_reg <= tx_sub_reg + 4'h1;
    end
  end

  // transmitter
  aasa_tx_type tx_st;
  logic [8:0] tx_sh_reg;
  logic [3:0] tx_cnt_reg;
  logic tx_line_reg, tx_par_reg;
  assign f_ready = (tx_st == TX_IDLE) && tx_bit;
  wire [3:0] tx_total = nbits + (par_on ? 4'h1 : 4'h0);

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I || (CE_I && do_clear)) begin
      tx_st <= TX_IDLE;
      tx_line_reg <= 1'b1;
      tx_sh_reg <= '0;
      tx_cnt_reg <= '0;
      tx_par_reg <= 1'b0;
    end else if (CE_I && tx_bit) begin
      unique case (tx_st)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (f_valid) begin
            tx_line_reg <= 1'b0;
            tx_sh_reg <= {1'b0, f_data};
            tx_par_reg <= !par_even;
            tx_cnt_reg <= '0;
            tx_st <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_cnt_reg == nbits) begin
            tx_line_reg <= tx_par_reg ^ 1'b0;
          end else begin
            tx_line_reg <= tx_sh_reg[0];
            tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
            tx_sh_reg <= tx_sh_reg >> 1;
          end
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
          if (tx_cnt_reg == tx_total - 4'h1) tx_st <= TX_STOP;
        end
        TX_STOP: begin
          tx_line_reg <= 1'b1;
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
          if (!two_stop || tx_cnt_reg == tx_total + 4'h1) begin
            tx_st <= TX_IDLE;
            tx_cnt_reg <= tx_total + 4'h1;
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end
  // shifter done and fifo drained frees the need flag
  wire tx_done = CE_I && tx_bit && (tx_st == TX_STOP) &&
                 (!two_stop || tx_cnt_reg == tx_total + 4'h1);

  // receiver, mid-bit sampling
  aasa_rx_type rx_st;
  logic [3:0] rx_sub_reg, rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic rx_perr_reg;
  wire [3:0] rx_total = nbits + (par_on ? 4'h1 : 4'h0);
  wire rx_mid = rx_tick && (rx_sub_reg == 4'h7);
  wire rx_stop_now = CE_I && rx_mid && (rx_st == RX_STOP);
  wire rx_fe = rx_stop_now && !RXD_I;
  wire rx_oe = rx_stop_now && rx_avail_reg;
  // align data to lsb for short words
  wire [7:0] rx_word = rx_sh_reg >> (4'h8 - nbits);

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I || (CE_I && do_clear)) begin
      rx_st <= RX_IDLE;
      rx_sub_reg <= '0;
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
      rx_perr_reg <= 1'b0;
    end else if (CE_I && rx_tick) begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
      unique case (rx_st)
        RX_IDLE: begin
          rx_sub_reg <= '0;
          if (!RXD_I) rx_st <= RX_START;
        end
        RX_START: if (rx_sub_reg == 4'h7) begin
          rx_sub_reg <= 4'h8;
          rx_cnt_reg <= '0;
          rx_perr_reg <= par_even ? 1'b0 : 1'b1;
          rx_st <= RXD_I ? RX_IDLE : RX_SHIFT; // false start rejected
        end
        RX_SHIFT: if (rx_sub_reg == 4'h7) begin
          if (rx_cnt_reg < nbits) rx_sh_reg <= {RXD_I, rx_sh_reg[7:1]};
          rx_perr_reg <= rx_perr_reg ^ RXD_I;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == rx_total - 4'h1) rx_st <= RX_STOP;
        end
        RX_STOP: if (rx_sub_reg == 4'h7) rx_st <= RX_IDLE;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end
  wire rx_pe = rx_stop_now && par_on && rx_perr_reg;

  // configuration registers
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      sel_reg <= 1'b0;
      params_reg <= PARAMS_RESET;
      rx_rate_reg <= RATE_RESET;
      modem_reg <= '0;
      in_data_mode_reg <= 1'b0;
      low_mode_reg <= 1'b0;
      ring_mode_reg <= 1'b0;
      txie_reg <= 1'b0;
    end else if (CE_I) begin
      if (SEL_STB_I) sel_reg <= (SEL_CODE_I == SELECT_CODE);
      if (do_clear) begin
        modem_reg <= '0;
        in_data_mode_reg <= 1'b0;
        low_mode_reg <= 1'b0;
        ring_mode_reg <= 1'b0;
      end
      if (do_modem) modem_reg <= CMD_DATA_I[3:0];
      if (do_params) begin
        params_reg <= CMD_DATA_I;
        rx_rate_reg <= CMD_DATA_I[3:0];
      end
      if (do_inmode) in_data_mode_reg <= CMD_DATA_I[0];
      if (do_aux) begin
        low_mode_reg <= aux_low;
        ring_mode_reg <= CMD_DATA_I[AX_RING];
        txie_reg <= CMD_DATA_I[AX_TXIE];
      end
      if (aux_rate_ok) rx_rate_reg <= CMD_DATA_I[3:0];
    end
  end

  // flags: a received character wins over a same-cycle read or clear; clear wins over output, output over the drain set; leaving ring mode wins over ring sets
  wire rx_done = rx_stop_now;
  wire rd_data = do_input && in_data_mode_reg;
  wire ring_leave = (do_clear || (do_aux && !CMD_DATA_I[AX_RING]));
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      rx_avail_reg <= 1'b0;
      err_reg <= 1'b0;
      tx_need_reg <= 1'b1;
      ring_irq_reg <= 1'b0;
      rx_buf_reg <= '0;
    end else if (CE_I) begin
      if (rx_done) begin
        rx_avail_reg <= 1'b1;
        rx_buf_reg <= rx_word;
        err_reg <= rx_pe || rx_oe || rx_fe;
      end else if (rd_data || do_clear) begin
        rx_avail_reg <= 1'b0;
      end
      if (do_clear && !rx_done) err_reg <= 1'b0;
      if (do_clear) tx_need_reg <= 1'b1;
      else if (do_output) tx_need_reg <= 1'b0;
      else if (tx_done && !f_valid) tx_need_reg <= 1'b1;
      if (ring_mode_reg && MODEM_I.ring && !ring_leave)
        ring_irq_reg <= 1'b1;
      else if (ring_leave) ring_irq_reg <= 1'b0;
    end
  end

  // read data register
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) rd_reg <= '0;
    else if (CE_I && do_input)
      rd_reg <= in_data_mode_reg ? rx_buf_reg : status;
  end
  assign RD_DATA_O = rd_reg;
  assign SELECTED_O = sel_reg;

  // single level-four request; ring mode locks out data sources
  assign IRQ_O = ring_mode_reg ? ring_irq_reg
               : (rx_avail_reg || (txie_reg && tx_need_reg));

  // modem outputs; break forces space on transmit data
  assign MODEM_O.txd = tx_line_reg && !modem_reg[MC_BREAK];
  assign MODEM_O.std = modem_reg[MC_STD];
  assign MODEM_O.dtr = modem_reg[MC_DTR];
  assign MODEM_O.rts = modem_reg[MC_RTS];

  // assertions
  AST_SEL_GATE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && !sel_reg && CMD_I == CMD_PARAMS |=> $stable(params_reg))
    else $error("params changed while unselected");
  AST_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && do_clear |=> tx_need_reg && modem_reg == 4'h0
      && !in_data_mode_reg && !ring_mode_reg && !low_mode_reg)
    else $error("clear did not reset state");
  AST_STATUS: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && do_input && !in_data_mode_reg |=>
      RD_DATA_O[7:5] == $past(status[7:5]))
    else $error("status read wrong");
  AST_OUT_NEED: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && do_output && !do_clear |=> !tx_need_reg)
    else $error("need flag not cleared by output");
  AST_DATA_RD: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && rd_data && !rx_done && !do_clear |=> !rx_avail_reg
      && RD_DATA_O == $past(rx_buf_reg))
    else $error("data read wrong");
  AST_RX_SET: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    rx_done |=> rx_avail_reg)
    else $error("received flag missing");
  AST_OVERRUN: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    rx_done && rx_avail_reg |=> err_reg)
    else $error("overrun not flagged");
  AST_RATE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && do_params |=> rx_rate_reg == params_reg[3:0])
    else $error("rates not equal");
  AST_RING_IRQ: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    ring_mode_reg && !ring_irq_reg |-> !IRQ_O)
    else $error("data irq in ring mode");
  AST_RING_CLR: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CE_I && do_clear |=> !ring_irq_reg ##1 !IRQ_O || !ring_mode_reg)
    else $error("ring irq kept");
  AST_BREAK: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    modem_reg[MC_BREAK] |-> !MODEM_O.txd)
    else $error("break not forced");
endmodule : aasa_adapter
`default_nettype wire

// [sim/aasa_modem_model.sv]
// behavioural modem facing the serial adapter's line side
`default_nettype none
module aasa_modem_model (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output aasa_pkg::aasa_modem_in_type lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import aasa_pkg::*;
  int bit_cyc = 512;
  int frames = 0;
  logic [10:0] cap;
  initial begin
    rxd_o = 1'b1;
    lines_o = '0;
  end
  // start bit plus ten more, mid-bit; trailing idle ones show up too
  always begin
    @(negedge txd_i);
    repeat (bit_cyc / 2) @(negedge clk_i);
    for (int i = 0; i < 11; i++) begin
      cap[i] = txd_i;
      if (i < 10) repeat (bit_cyc) @(negedge clk_i);
    end
    frames++;
  end
  // lsb first; the line returns to mark so no stale level lingers
  task automatic send(input logic [10:0] f, input int cyc);
    for (int i = 0; i < 11; i++) begin
      rxd_o = f[i];
      repeat (cyc) @(negedge clk_i);
    end
    rxd_o = 1'b1;
  endtask : send
  task automatic set_lines(input aasa_modem_in_type v);
    lines_o = v;
  endtask : set_lines
endmodule : aasa_modem_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the async serial adapter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aasa_pkg::*;
  localparam int BIT = 512; // 16 ticks of 32 clocks at code f
  logic clk = 1'b0;
  logic rst, ce, sel_stb, cmd_ready, selected, irq, rxd;
  logic [7:0] sel_code, cmd_data, rd_data, st;
  aasa_cmd_type cmd;
  aasa_modem_in_type lines;
  aasa_modem_out_type mout;
  logic [3:0] mc [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  int errors = 0;
  int checked = 0;
  int nf = 0;
  always #50 clk = ~clk;
  aasa_adapter aasa_adapter_inst (
    .CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce), .SEL_STB_I(sel_stb),
    .SEL_CODE_I(sel_code), .CMD_I(cmd), .CMD_DATA_I(cmd_data),
    .RD_DATA_O(rd_data), .CMD_READY_O(cmd_ready),
    .SELECTED_O(selected), .IRQ_O(irq), .RXD_I(rxd),
    .MODEM_I(lines), .MODEM_O(mout));
  aasa_modem_model aasa_modem_model_inst (
    .clk_i(clk), .txd_i(mout.txd), .rxd_o(rxd), .lines_o(lines));
  task automatic check(input string nm, input logic [10:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one-cycle command pulse, launched and dropped on falling edges
  task automatic do_cmd(input aasa_cmd_type c, input logic [7:0] d);
    @(negedge clk);
    cmd = c;
    cmd_data = d;
    @(negedge clk);
    cmd = CMD_NONE;
  endtask : do_cmd
  task automatic sel(input logic [7:0] c);
    @(negedge clk);
    sel_stb = 1'b1;
    sel_code = c;
    @(negedge clk);
    sel_stb = 1'b0;
  endtask : sel
  task automatic read_in;
    do_cmd(CMD_INPUT, 8'h00);
    @(negedge clk);
    st = rd_data;
  endtask : read_in
  task automatic status(input logic [7:0] exp);
    do_cmd(CMD_INMODE, 8'h00);
    read_in();
    check("status", st, exp);
  endtask : status
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk);
    check("irq", irq, exp);
  endtask : chk_irq
  // bounded wait for the modem to finish sampling a frame
  task automatic wait_tx;
    int k;
    nf++;
    for (k = 0; k < 20000 && aasa_modem_model_inst.frames != nf; k++)
      @(negedge clk);
    check("tx_frame_seen", aasa_modem_model_inst.frames, nf);
    repeat (BIT) @(negedge clk);
  endtask : wait_tx
  // 8 data bits, odd parity unless bad is set, one stop
  task automatic rx_char(input logic [7:0] d, input logic bad,
                         input int cyc);
    aasa_modem_model_inst.send({1'b1, ~^d ^ bad, d, 1'b0}, cyc);
  endtask : rx_char
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // hang guard, well past the roughly 60k cycles the tests need
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("MISMATCH watchdog expired");
    end_sim();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sel_stb = 1'b0;
    sel_code = 8'h00;
    cmd = CMD_NONE;
    cmd_data = 8'h00;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    // commands before selection must be ignored
    do_cmd(CMD_MODEM, 8'h07);
    check("modem_unsel", mout, 4'b1000);
    sel(8'h2c);
    check("selected", selected, 1'b0);
    sel(SELECT_CODE);
    check("selected", selected, 1'b1);
    status(8'h40);
    aasa_modem_model_inst.set_lines(5'h1e);
    status(8'h5e);
    foreach (mc[i]) begin
      do_cmd(CMD_MODEM, {4'h0, mc[i]});
      check("modem_out", mout, {~mc[i][3], mc[i][2:0]});
    end
    do_cmd(CMD_MODEM, 8'h00);
    // the break above looked like a frame to the modem; let it pass
    repeat (6000) @(negedge clk);
    nf = aasa_modem_model_inst.frames;
    // 8 data, odd parity, one stop, transmit interrupt on
    do_cmd(CMD_PARAMS, 8'h4f);
    do_cmd(CMD_AUX, 8'h2f);
    chk_irq(1'b1);
    do_cmd(CMD_OUTPUT, 8'h41);
    status(8'h1e);
    chk_irq(1'b0);
    wait_tx();
    check("tx_frame", aasa_modem_model_inst.cap,
          {1'b1, 1'b1, 8'h41, 1'b0});
    status(8'h5e);
    chk_irq(1'b1);
    // low mode set before params, rate after, bit 7 held
    do_cmd(CMD_AUX, 8'h80);
    do_cmd(CMD_PARAMS, 8'h0f);
    do_cmd(CMD_AUX, 8'h8f);
    do_cmd(CMD_OUTPUT, 8'h15);
    wait_tx();
    check("tx_low", aasa_modem_model_inst.cap,
          {3'h7, 1'b1, 1'b0, 5'h15, 1'b0});
    // fill the transmit queue until refused, then clear before any frame starts
    do_cmd(CMD_MODEM, 8'h07);
    do_cmd(CMD_INMODE, 8'h01);
    for (int i = 0; i < 12 && cmd_ready; i++)
      do_cmd(CMD_OUTPUT, 8'hff);
    check("cmd_ready_full", cmd_ready, 1'b0);
    do_cmd(CMD_CLEAR, 8'h00);
    check("modem_clr", mout, 4'b1000);
    check("cmd_ready_clr", cmd_ready, 1'b1);
    read_in();
    check("status_clr", st, 8'h5e);
    repeat (6000) @(negedge clk);
    nf = aasa_modem_model_inst.frames;
    // receive path at 19200 both ways
    do_cmd(CMD_PARAMS, 8'h4f);
    rx_char(8'ha5, 1'b0, BIT);
    status(8'hde);
    chk_irq(1'b1);
    do_cmd(CMD_INMODE, 8'h01);
    read_in();
    check("rx_data", st, 8'ha5);
    chk_irq(1'b0);
    status(8'h5e);
    rx_char(8'h3c, 1'b1, BIT);
    status(8'hfe);
    do_cmd(CMD_INMODE, 8'h01);
    read_in();
    status(8'h7e);
    rx_char(8'h5a, 1'b0, BIT);
    status(8'hde);
    rx_char(8'h69, 1'b0, BIT);
    status(8'hfe);
    do_cmd(CMD_INMODE, 8'h01);
    read_in();
    // receive alone moved to 9600, transmit stays at 19200
    do_cmd(CMD_AUX, 8'h0e);
    rx_char(8'h66, 1'b0, 1040);
    do_cmd(CMD_INMODE, 8'h01);
    read_in();
    check("rx_slow", st, 8'h66);
    // ring mode: data terminal ready off, only the ring may interrupt
    do_cmd(CMD_MODEM, 8'h00);
    do_cmd(CMD_AUX, 8'h6f);
    chk_irq(1'b0);
    aasa_modem_model_inst.set_lines(5'h1f);
    chk_irq(1'b1);
    status(8'h5f);
    do_cmd(CMD_AUX, 8'h0f);
    chk_irq(1'b0);
    aasa_modem_model_inst.set_lines(5'h1e);
    // clock enable low freezes state: a modem command has no effect
    ce = 1'b0;
    do_cmd(CMD_MODEM, 8'h02);
    check("modem_frozen", mout, 4'b1000);
    ce = 1'b1;
    end_sim();
  end
endmodule : tb
`default_nettype wire
